// >>> verification/cds_data_irq_bench.sv
`timescale 1ns/1ps
module cds_data_irq_bench;
  import cds_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reqValid = 1'b0, rfWe = 1'b0, instrEnd = 1'b0;
  logic seiExec = 1'b0, retiExec = 1'b0, sleeping = 1'b0;
  cdsReq_t req = '0;
  logic [4:0] rfWrIdx = 5'h00, rfRdIdx = 5'h00;
  logic [7:0] rfWrData = 8'h00, ansData, rfRdData, ioRdData, rd, v, ack;
  logic [15:0] pcCur = 16'h0000, handlerAddr = 16'h0000, pcNext, sp, sp0, a;
  logic [7:0] irqPend = 8'h00, irqEnable = 8'hFF, irqAck;
  logic reqReady, ansDone, seqBusy, pcLoad, gie, s, x;
  logic [8:0] wq;
  cdsIoBus_t io;
  int errors = 0, checked = 0, seed = 32'h137ED8CE, n;
  logic [15:0] corner [9] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F, 16'h0060,
    16'h00FF, 16'h0100, 16'h02FF, 16'h0300};

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  cds_data_irq u_cds_data_irq (.core_clk(core_clk), .rst(rst), .reqValid(reqValid),
    .req(req), .reqReady(reqReady), .ansDone(ansDone), .ansData(ansData), .rfWe(rfWe),
    .rfWrIdx(rfWrIdx), .rfWrData(rfWrData), .rfRdIdx(rfRdIdx), .rfRdData(rfRdData),
    .io(io), .ioRdData(ioRdData), .instrEnd(instrEnd), .seiExec(seiExec),
    .cliExec(1'b0), .retiExec(retiExec), .sleeping(sleeping), .pcCur(pcCur),
    .handlerAddr(handlerAddr), .irqPend(irqPend), .irqEnable(irqEnable), .irqAck(irqAck),
    .seqBusy(seqBusy), .pcLoad(pcLoad), .pcNext(pcNext), .gie(gie), .sp(sp));

  cds_periph_model u_cds_periph_model (.core_clk(core_clk), .io(io), .ioRdData(ioRdData));

  task automatic give_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  // Inputs always move 2 ns after the rising edge
  task automatic tick;
    @(posedge core_clk);
    #2;
  endtask : tick

  // One data access; held until taken, strobes seen in cycle 1, answer in cycle 2
  task automatic acc(input logic w, input logic so, input cdsMode_t m, input cdsPtr_t p,
                     input logic [5:0] dp, input logic [15:0] ad, input logic [7:0] wd);
    int k;
    req = '{w, so, m, p, dp, ad, wd};
    reqValid = 1'b1;
    for (k = 0; k < 20 && reqReady !== 1'b1; k++) tick();
    if (k >= 20) begin
      errors++;
      $display("[ERR] %0t access never taken", $time);
      give_verdict();
    end
    tick();
    reqValid = 1'b0;
    s = io.stdSel;
    x = io.extSel;
    wq = {io.we, io.wdata};
    tick();
    chk(ansDone, 1'b1);
    rd = ansData;
  endtask : acc

  // Writes a pointer pair, low byte first, with the strobe held across both
  task automatic rfw(input logic [4:0] i, input logic [15:0] d);
    rfWe = 1'b1;
    rfWrIdx = i;
    rfWrData = d[7:0];
    tick();
    rfWrIdx = i + 5'h01;
    rfWrData = d[15:8];
    tick();
    rfWe = 1'b0;
  endtask : rfw

  // Reads a pair one byte per cycle so the index moves only at the drive point
  task automatic ptrChk(input logic [4:0] i, input logic [15:0] e);
    logic [7:0] lo;
    rfRdIdx = i;
    tick();
    lo = rfRdData;
    rfRdIdx = i + 5'h01;
    tick();
    chk({rfRdData, lo}, e);
  endtask : ptrChk

  // One instruction boundary; the grant is looked at in its own cycle
  task automatic bnd(input logic se, input logic re);
    instrEnd = 1'b1;
    seiExec = se;
    retiExec = re;
    #1 ack = irqAck;
    tick();
    instrEnd = 1'b0;
    seiExec = 1'b0;
    retiExec = 1'b0;
  endtask : bnd

  // Counts cycles until the counter load, the current cycle being 1
  task automatic waitPc;
    n = 1;
    while (pcLoad !== 1'b1 && n < 30) begin
      tick();
      n++;
    end
    if (n >= 30) begin
      errors++;
      $display("[ERR] %0t no counter load", $time);
      give_verdict();
    end
  endtask : waitPc

  function automatic logic [7:0] expRd(input logic [15:0] ad, input logic [7:0] wv);
    if (ad <= 16'h001F || (ad >= 16'h0100 && ad <= 16'h02FF)) return wv;
    if (ad <= 16'h00FF) return ad[7:0] ^ 8'h5A;
    return 8'h00;
  endfunction : expRd

  // Expected peripheral selects: standard then extended
  function automatic logic [1:0] expSel(input logic [15:0] ad);
    return {ad >= 16'h0020 && ad <= 16'h005F, ad >= 16'h0060 && ad <= 16'h00FF};
  endfunction : expSel

  initial begin
    repeat (6) @(posedge core_clk);
    #2 rst = 1'b0;
    chk(sp, 16'h02FF);
    chk(gie, 1'b0);
    // Region corners first, then random addresses reaching past the SRAM end
    for (int i = 0; i < 30; i++) begin
      a = (i < 9) ? corner[i] : 16'($random(seed)) & 16'h03FF;
      v = 8'($random(seed));
      acc(1'b1, 1'b0, CDS_DIRECT, CDS_PX, 6'h00, a, v);
      chk({s, x}, expSel(a));
      chk(wq, {|expSel(a), v});
      acc(1'b0, 1'b0, CDS_DIRECT, CDS_PX, 6'h00, a, 8'h00);
      chk(rd, expRd(a, v));
    end
    // Pointer modes back to back on the first pair, displacement at its limit
    rfw(5'h1A, 16'h0150);
    acc(1'b1, 1'b0, CDS_POSTINC, CDS_PX, 6'h00, 16'h0000, 8'hA5);
    ptrChk(5'h1A, 16'h0151);
    acc(1'b0, 1'b0, CDS_PREDEC, CDS_PX, 6'h00, 16'h0000, 8'h00);
    ptrChk(5'h1A, 16'h0150);
    chk(rd, 8'hA5);
    rfw(5'h1C, 16'h0140);
    acc(1'b1, 1'b0, CDS_DISP, CDS_PY, 6'h3F, 16'h0000, 8'h3C);
    acc(1'b0, 1'b0, CDS_DIRECT, CDS_PX, 6'h00, 16'h017F, 8'h00);
    chk(rd, 8'h3C);
    // Short form at its top number stays in standard I/O
    acc(1'b0, 1'b1, CDS_DIRECT, CDS_PX, 6'h00, 16'h003F, 8'h00);
    chk({s, x, rd}, {2'b10, 8'h5F ^ 8'h5A});
    // Pending with the global enable off, then an enable boundary with it on
    irqPend = 8'h0C;
    irqEnable = 8'hFB;
    bnd(1'b0, 1'b0);
    chk(ack, 8'h00);
    tick();
    bnd(1'b1, 1'b0);
    chk(ack, 8'h00);
    chk(gie, 1'b1);
    tick();
    bnd(1'b1, 1'b0);
    chk(ack, 8'h00);
    // Enabled and pending, but no instruction has ended
    tick();
    chk(irqAck, 8'h00);
    pcCur = 16'h1234;
    handlerAddr = 16'h0ABC;
    sp0 = sp;
    bnd(1'b0, 1'b0);
    chk(ack, 8'h08);
    chk({seqBusy, reqReady}, 2'b10);
    irqPend = 8'h04;
    waitPc();
    chk(n, 5);
    chk(pcNext, 16'h0008);
    chk(sp, sp0 - 16'h0002);
    chk(gie, 1'b0);
    tick();
    waitPc();
    chk(n, 3);
    chk(pcNext, 16'h0ABC);
    pcCur = 16'h0000;
    bnd(1'b0, 1'b1);
    waitPc();
    chk(n, 5);
    chk(pcNext, 16'h1234);
    chk(sp, sp0);
    chk(gie, 1'b1);
    // Right after the return nothing is granted without a boundary
    irqPend = 8'h0C;
    irqEnable = 8'hFF;
    #1 chk(irqAck, 8'h00);
    tick();
    // Wake from sleep without a boundary; the lower vector wins
    pcCur = 16'h2222;
    sleeping = 1'b1;
    #1 chk(irqAck, 8'h04);
    tick();
    irqPend = 8'h00;
    waitPc();
    sleeping = 1'b0;
    chk(n, 9);
    chk(pcNext, 16'h0006);
    chk(sp, sp0 - 16'h0002);
    give_verdict();
  end
endmodule : cds_data_irq_bench

// >>> verification/cds_periph_model.sv
`timescale 1ns/1ps
module cds_periph_model
  import cds_pkg::*;
(
  input wire logic core_clk,
  input wire cdsIoBus_t io,
  output logic [7:0] ioRdData
);
  logic [7:0] lastData_q = 8'h00;
  // A selected register answers with a pattern of its own address
  // An unselected bus never repeats the last value, so stale data cannot pass
  always_comb begin
    if (io.stdSel | io.extSel) ioRdData = io.addr ^ 8'h5A;
    else ioRdData = ~lastData_q;
  end
  // Remember what was last driven
  always_ff @(posedge core_clk) lastData_q <= ioRdData;
endmodule : cds_periph_model

// >>> verilog/cds_cfg.svh
`ifndef CDS_CFG_SVH
`define CDS_CFG_SVH
// Data space map
`define CDS_REG_END 16'h001F
`define CDS_IO_BASE 16'h0020
`define CDS_IO_END 16'h005F
`define CDS_EXT_END 16'h00FF
`define CDS_SRAM_BASE 16'h0100
`define CDS_SRAM_END 16'h02FF
`define CDS_SP_RESET 16'h02FF
// Pointer pair low-byte indexes
`define CDS_PTR_X 5'h1A
`define CDS_PTR_Y 5'h1C
`define CDS_PTR_Z 5'h1E
// Sequencer cycle counts
`define CDS_ENTRY_CYC 3'h4
`define CDS_WAKE_CYC 3'h4
`define CDS_JUMP_CYC 3'h3
`define CDS_RET_CYC 3'h4
// Vectors are two words apart; vector 0 is reset
`define CDS_VEC_SHIFT 1
`define CDS_STEP 16'h0001
`endif

// >>> verilog/cds_data_irq.sv
// Functional notes
// - Instruction after enable runs before interrupt
// - Entry takes four cycles, pushes counter
// - Vector jump takes three more cycles
// - Multi-cycle instruction completes before entry
// - Wake from sleep adds four cycles
// - Interrupt return takes four cycles
// - Return pops counter, stack up two, enables
// - Addresses up to 0x1F hit registers
// - 0x20 to 0x5F hit standard I/O
// - 0x60 to 0xFF hit extended I/O
// - 512 SRAM bytes sit above extended I/O
// - Short I/O form never reaches extended I/O
// - Direct addressing reaches whole data space
// - Displacement reaches 63 past Y or Z
// - Pre-decrement before, post-increment after access
// - Registers 26 to 31 are pointer pairs
// - SRAM access completes in two cycles
// - Entry clears the global enable
// - Pushing return address lowers stack by two
// - Lower vector wins; reset ranks first
// - One main instruction runs after return
`timescale 1ns/1ps
`include "cds_cfg.svh"
module cds_data_irq
  import cds_pkg::*;
#(
  parameter int NIRQ = 8,
  parameter int SRAM_BYTES = 512
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire cdsReq_t req,
  output logic reqReady,
  output logic ansDone,
  output logic [7:0] ansData,
  input wire logic rfWe,
  input wire logic [4:0] rfWrIdx,
  input wire logic [7:0] rfWrData,
  input wire logic [4:0] rfRdIdx,
  output logic [7:0] rfRdData,
  output cdsIoBus_t io,
  input wire logic [7:0] ioRdData,
  input wire logic instrEnd,
  input wire logic seiExec,
  input wire logic cliExec,
  input wire logic retiExec,
  input wire logic sleeping,
  input wire logic [15:0] pcCur,
  input wire logic [15:0] handlerAddr,
  input wire logic [NIRQ-1:0] irqPend,
  input wire logic [NIRQ-1:0] irqEnable,
  output logic [NIRQ-1:0] irqAck,
  output logic seqBusy,
  output logic pcLoad,
  output logic [15:0] pcNext,
  output logic gie,
  output logic [15:0] sp
);
  localparam int IW = (NIRQ > 1) ? $clog2(NIRQ) : 1;
  localparam int SW = $clog2(SRAM_BYTES);

  logic [7:0] rf [0:31];
  logic [7:0] mem [0:SRAM_BYTES-1];
  cdsState_t state_q;
  logic [2:0] cnt_q;
  logic gie_q;
  logic [15:0] sp_q;
  logic [15:0] retPc_q;
  logic [IW-1:0] win_q;
  logic pcLoad_q;
  logic [15:0] pcNext_q;
  logic stg_q;
  logic stgWr_q;
  cdsTgt_t stgTgt_q;
  logic [15:0] stgAddr_q;
  logic [7:0] stgData_q;
  cdsIoBus_t io_q;
  logic ansDone_q;
  logic [7:0] ansData_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  function automatic logic [SW-1:0] sramIdx(input logic [15:0] a);
    logic [15:0] t;
    t = a - `CDS_SRAM_BASE;
    return t[SW-1:0];
  endfunction : sramIdx

  // Requests that are both pending and individually enabled
  logic [NIRQ-1:0] act;
  logic [IW-1:0] winIdx;
  assign act = irqPend & irqEnable;
  always_comb begin
    winIdx = '0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (act[i]) begin
        winIdx = IW'(i);
      end
    end
  end

  // Entry only at a boundary or on wake from sleep, and never on the boundary of SEI or CLI
  logic idle;
  logic take;
  logic wake;
  logic retStart;
  assign idle = (state_q == S_IDLE);
  assign take = idle && instrEnd && gie_q && (|act) && !sleeping
    && !seiExec && !cliExec && !retiExec;
  assign wake = idle && sleeping && gie_q && (|act);
  assign retStart = idle && instrEnd && retiExec && !take;
  assign irqAck = (take || wake) ? (NIRQ'(1) << winIdx) : '0;

  // Vector address from the winner's slot, reset holding slot 0
  logic [15:0] vecAddr;
  assign vecAddr = (16'(win_q) + `CDS_STEP) << `CDS_VEC_SHIFT;

  // Sequencer state and step counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= 3'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          cnt_q <= 3'h0;
          if (wake) begin
            state_q <= S_WAKE;
          end else if (take) begin
            state_q <= S_ENTRY;
          end else if (retStart) begin
            state_q <= S_RET;
          end
        end
        S_WAKE: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `CDS_WAKE_CYC - 3'h1) begin
            cnt_q <= 3'h0;
            state_q <= S_ENTRY;
          end
        end
        S_ENTRY: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `CDS_ENTRY_CYC - 3'h1) begin
            cnt_q <= 3'h0;
            state_q <= S_JUMP;
          end
        end
        S_JUMP: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `CDS_JUMP_CYC - 3'h1) begin
            cnt_q <= 3'h0;
            state_q <= S_IDLE;
          end
        end
        S_RET: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `CDS_RET_CYC - 3'h1) begin
            cnt_q <= 3'h0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Winner and return address latched when entry is granted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      win_q <= '0;
      retPc_q <= 16'h0000;
    end else if (take || wake) begin
      win_q <= winIdx;
      retPc_q <= pcCur;
    end
  end

  // Global enable; entry clear wins over a same-cycle SEI
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gie_q <= 1'b0;
    end else if (take || wake) begin
      gie_q <= 1'b0;
    end else if (state_q == S_RET && cnt_q == `CDS_RET_CYC - 3'h1) begin
      gie_q <= 1'b1;
    end else if (instrEnd && cliExec) begin
      gie_q <= 1'b0;
    end else if (instrEnd && seiExec) begin
      gie_q <= 1'b1;
    end
  end

  // Stack pointer moves one byte per push or pop step
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sp_q <= `CDS_SP_RESET;
    end else if (state_q == S_ENTRY && cnt_q < 3'h2) begin
      sp_q <= sp_q - `CDS_STEP;
    end else if (state_q == S_RET && cnt_q < 3'h2) begin
      sp_q <= sp_q + `CDS_STEP;
    end
  end

  // Counter loads: vector, handler, then popped return address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pcLoad_q <= 1'b0;
      pcNext_q <= 16'h0000;
    end else begin
      pcLoad_q <= 1'b0;
      if (state_q == S_ENTRY && cnt_q == `CDS_ENTRY_CYC - 3'h1) begin
        pcLoad_q <= 1'b1;
        pcNext_q <= vecAddr;
      end else if (state_q == S_JUMP && cnt_q == `CDS_JUMP_CYC - 3'h1) begin
        pcLoad_q <= 1'b1;
        pcNext_q <= handlerAddr;
      end else if (state_q == S_RET && cnt_q == 3'h1) begin
        pcNext_q[15:8] <= mem[sramIdx(sp_q)];
      end else if (state_q == S_RET && cnt_q == 3'h2) begin
        pcNext_q[7:0] <= mem[sramIdx(sp_q)];
      end else if (state_q == S_RET && cnt_q == `CDS_RET_CYC - 3'h1) begin
        pcLoad_q <= 1'b1;
      end
    end
  end

  // Effective address: pointer pair, displacement, short I/O
  logic [4:0] pBase;
  logic [15:0] ptrVal;
  logic [15:0] effAddr;
  logic [15:0] ptrNew;
  logic ptrUpd;
  cdsTgt_t tgt;
  always_comb begin
    case (req.ptr)
      CDS_PY: pBase = `CDS_PTR_Y;
      CDS_PZ: pBase = `CDS_PTR_Z;
      default: pBase = `CDS_PTR_X;
    endcase
    ptrVal = {rf[pBase + 5'h01], rf[pBase]};
    ptrNew = ptrVal;
    ptrUpd = 1'b0;
    effAddr = req.addr;
    if (req.shortIo) begin
      effAddr = {10'h000, req.addr[5:0]} + `CDS_IO_BASE;
    end else if (req.mode == CDS_DISP) begin
      effAddr = ptrVal + {10'h000, req.disp};
    end else if (req.mode == CDS_IND) begin
      effAddr = ptrVal;
    end else if (req.mode == CDS_PREDEC) begin
      ptrNew = ptrVal - `CDS_STEP;
      effAddr = ptrNew;
      ptrUpd = 1'b1;
    end else if (req.mode == CDS_POSTINC) begin
      ptrNew = ptrVal + `CDS_STEP;
      effAddr = ptrVal;
      ptrUpd = 1'b1;
    end
    if (effAddr <= `CDS_REG_END) begin
      tgt = TGT_REGS;
    end else if (effAddr <= `CDS_IO_END) begin
      tgt = TGT_IO;
    end else if (effAddr <= `CDS_EXT_END) begin
      tgt = TGT_EXT;
    end else if (effAddr <= `CDS_SRAM_END) begin
      tgt = TGT_SRAM;
    end else begin
      tgt = TGT_NONE;
    end
  end

  logic accept;
  // Refused on a take cycle (not on wake): its store would collide with the first stack push
  assign reqReady = !stg_q && idle && !take;
  assign accept = reqValid && reqReady;

  // Access stage: first cycle takes the address, second performs it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stg_q <= 1'b0;
      stgWr_q <= 1'b0;
      stgTgt_q <= TGT_NONE;
      stgAddr_q <= 16'h0000;
      stgData_q <= 8'h00;
    end else begin
      stg_q <= accept;
      if (accept) begin
        stgWr_q <= req.write;
        stgTgt_q <= tgt;
        stgAddr_q <= effAddr;
        stgData_q <= req.wdata;
      end
    end
  end

  // Peripheral strobes stand for the second cycle only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_q <= '0;
    end else begin
      io_q.stdSel <= accept && tgt == TGT_IO;
      io_q.extSel <= accept && tgt == TGT_EXT;
      io_q.we <= accept && req.write && (tgt == TGT_IO || tgt == TGT_EXT);
      if (accept) begin
        io_q.addr <= effAddr[7:0];
        io_q.wdata <= req.wdata;
      end
    end
  end

  // Answer registered at the end of the second cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ansDone_q <= 1'b0;
      ansData_q <= 8'h00;
    end else begin
      ansDone_q <= stg_q;
      if (stg_q && !stgWr_q) begin
        case (stgTgt_q)
          TGT_REGS: ansData_q <= rf[stgAddr_q[4:0]];
          TGT_IO, TGT_EXT: ansData_q <= ioRdData;
          TGT_SRAM: ansData_q <= mem[sramIdx(stgAddr_q)];
          default: ansData_q <= 8'h00;
        endcase
      end
    end
  end

  // Working registers; storage, so no reset
  always_ff @(posedge core_clk) begin
    if (rfWe) begin
      rf[rfWrIdx] <= rfWrData;
    end
    if (accept && ptrUpd) begin
      rf[pBase] <= ptrNew[7:0];
      rf[pBase + 5'h01] <= ptrNew[15:8];
    end
    if (stg_q && stgWr_q && stgTgt_q == TGT_REGS) begin
      rf[stgAddr_q[4:0]] <= stgData_q;
    end
  end

  // SRAM; stack pushes and data stores never overlap
  always_ff @(posedge core_clk) begin
    if (state_q == S_ENTRY && cnt_q == 3'h0) begin
      mem[sramIdx(sp_q)] <= retPc_q[7:0];
    end else if (state_q == S_ENTRY && cnt_q == 3'h1) begin
      mem[sramIdx(sp_q)] <= retPc_q[15:8];
    end else if (stg_q && stgWr_q && stgTgt_q == TGT_SRAM) begin
      mem[sramIdx(stgAddr_q)] <= stgData_q;
    end
  end

  assign rfRdData = rf[rfRdIdx];
  assign io = io_q;
  assign ansDone = ansDone_q;
  assign ansData = ansData_q;
  assign seqBusy = !idle;
  assign pcLoad = pcLoad_q;
  assign pcNext = pcNext_q;
  assign gie = gie_q;
  assign sp = sp_q;

  // Checks on sequencer timing and decoding
  sequence s_entry4;
    (state_q == S_ENTRY)[*4];
  endsequence
  sequence s_jump3;
    (state_q == S_JUMP)[*3];
  endsequence

  a_sei_no_take: assert property (instrEnd && seiExec |-> irqAck == '0)
    else $error("interrupt taken on enable boundary");
  a_entry_len: assert property (take |=> s_entry4 ##1 (state_q == S_JUMP))
    else $error("entry length wrong");
  a_jump_len: assert property (take |=> s_entry4 ##1 s_jump3 ##1 idle)
    else $error("jump length wrong");
  a_wake_len: assert property (wake |=> (state_q == S_WAKE)[*4] ##1 s_entry4)
    else $error("wake latency wrong");
  a_ret_len: assert property (retStart |=> (state_q == S_RET)[*4] ##1 (idle && gie_q))
    else $error("return length wrong");
  a_sp_pop: assert property (retStart |=> ##2 sp_q == $past(sp_q, 3) + `CDS_STEP + `CDS_STEP)
    else $error("return did not raise stack by two");
  a_sp_push: assert property (take |=> ##2 sp_q == $past(sp_q, 3) - `CDS_STEP - `CDS_STEP)
    else $error("entry did not lower stack by two");
  a_gie_clear: assert property ((take || wake) |=> !gie_q)
    else $error("global enable left set on entry");
  a_sram_two: assert property (accept |=> !ansDone ##1 ansDone)
    else $error("access not done in two cycles");
  a_none_zero: assert property (accept && tgt == TGT_NONE && !req.write |=> ##1 ansData == 8'h00)
    else $error("unmapped read not zero");
  a_prio_low: assert property (irqAck != '0 |-> ((irqAck - NIRQ'(1)) & act) == '0)
    else $error("lower vector not preferred");
endmodule : cds_data_irq

// >>> verilog/cds_pkg.sv
package cds_pkg;
  typedef enum logic [2:0] {
    CDS_DIRECT, CDS_DISP, CDS_IND, CDS_PREDEC, CDS_POSTINC
  } cdsMode_t;
  typedef enum logic [1:0] {CDS_PX, CDS_PY, CDS_PZ} cdsPtr_t;
  typedef enum logic [2:0] {
    TGT_REGS, TGT_IO, TGT_EXT, TGT_SRAM, TGT_NONE
  } cdsTgt_t;
  typedef enum logic [2:0] {
    S_IDLE, S_WAKE, S_ENTRY, S_JUMP, S_RET
  } cdsState_t;
  // One data access from the pipeline
  typedef struct packed {
    logic write;
    logic shortIo;
    cdsMode_t mode;
    cdsPtr_t ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cdsReq_t;
  // Strobes toward peripheral registers
  typedef struct packed {
    logic stdSel;
    logic extSel;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cdsIoBus_t;
endpackage : cds_pkg
